// [gauge_status_shutdown_smbus.sv]
// Contract
// - Reset output held low at power-up, in hard-off and on low rail.
// - Reset output released a fixed delay after rail passes upper threshold.
// - Hard-off pin low forces config, flags, alert and link registers to their reset values.
// - Both gate drives stay high impedance during the reset timeout.
// - Setting the soft-off config bit enters soft shutdown.
// - Soft shutdown clears all pending flags and releases the alert.
// - In soft shutdown only the regulator, bus interface and both gate drives keep working.
// - Leaving soft shutdown does not reset; config and counters are kept.
// - The device is a bus slave only and never starts a transfer.
// - The alert output is an open-drain, active-low alert line.
// - Seven-bit slave address 1000111 is answered, and 0001100 only while an alert is pending.
// - Status is read by Read-Word, or by Receive-Byte instead.
// - Each received command code stays latched until replaced.
// - After a status command, Receive-Byte returns the status low byte.
// - Status bits 15 to 8 and bit 0 always read as one.
// - Bit 7 sets on discharge overcurrent; clears on soft, reset, clear.
// - Bit 6 sets on charge overcurrent; clears on soft, reset, clear.
// - Bit 5 sets on compare interrupt; clears on soft, reset, clear.
// - Bit 4 mirrors the counter-select config bit.
// - Bit 3 reads one in soft shutdown, zero otherwise and at reset.
// - Bit 2 sets on charging current and clears on discharging current.
// - Bit 1 sets on direction change; clears on clear, soft, reset.
// - Config bit 9 is the soft-off control, zero after reset.
// - Writing one to config bit 7 clears the four sticky flags.
// - A pending alert answers the alert response read with 0x8f.
`default_nettype none
`include "gauge_params.svh"

module gauge_status_shutdown_smbus #(
  parameter int POR_DELAY_CYCLES = `POR_DELAY_CYCLES
) (
  // Clocks and reset
  input  wire logic     clk_sys,
  input  wire logic     reset,
  input  wire logic     scl_clk,
  // Two-wire bus data line
  input  wire logic     sda_in,
  output logic          sda_out,
  output logic          sda_oe,
  // Alert line
  output logic          alert_out,
  output logic          alert_oe,
  // Power supervision
  input  wire logic     hard_off_n,
  input  wire logic     rail_below_low_threshold,
  input  wire logic     rail_above_release_threshold,
  output logic          por_out,
  output logic          por_oe,
  // Gate drives
  input  wire logic     charge_overcurrent_live,
  input  wire logic     discharge_overcurrent_live,
  output logic          charge_gate_drive_out,
  output logic          charge_gate_drive_oe,
  output logic          discharge_gate_drive_out,
  output logic          discharge_gate_drive_oe,
  // Measurement events
  input  wire logic     discharge_overcurrent_event,
  input  wire logic     charge_overcurrent_event,
  input  wire logic     compare_interrupt,
  input  wire logic     charge_detect,
  input  wire logic     discharge_detect,
  // Control and status to the gauge core
  output gauge_pkg::word_t config_word,
  output logic          counter_clear,
  output logic          functions_enable,
  output gauge_pkg::word_t device_status_word
);
  import gauge_pkg::*;

  // Open-drain pins only ever pull low.
  assign sda_out                  = 1'b0;
  assign alert_out                = 1'b0;
  assign por_out                  = 1'b0;
  assign charge_gate_drive_out    = 1'b0;
  assign discharge_gate_drive_out = 1'b0;

  logic        scl_s;
  logic        sda_s;
  logic        hard_off_n_s;
  logic        rail_low_s;
  logic        rail_ok_s;
  logic        chg_live_s;
  logic        dis_live_s;
  logic [6:0]  pins_s;
  logic        sda_prev;
  logic        in_frame;
  logic        frame_clear;
  logic        bus_start;
  logic        bus_stop;
  logic        link_clear;
  logic        link_hard;
  logic        por_done;
  logic        next_por_active;
  logic        cfg_toggle;
  logic        ara_toggle;
  logic [1:0]  evt_s;
  logic        cfg_s;
  logic        ara_s;
  logic        cfg_prev;
  logic        ara_prev;
  logic        cfg_strobe;
  logic        ara_strobe;
  word_t       cfg_hold;
  logic        interrupt_clear_bit;
  logic        soft_off;
  logic        run;
  logic [2:0]  sticky_set;
  logic [2:0]  sticky;
  logic        discharge_overcurrent_flag;
  logic        charge_overcurrent_flag;
  logic        compare_event_flag;
  logic        charging_direction_flag;
  logic        next_charging;
  logic        dir_change;
  logic        direction_flip_flag;
  logic        alert_raise;
  word_t       status_now;
  word_t       status_snap;
  logic        alert_snap;

  sync2 #(.WIDTH(7)) u_pin_sync (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({discharge_overcurrent_live, charge_overcurrent_live,
             rail_above_release_threshold, rail_below_low_threshold,
             hard_off_n, sda_in, scl_clk}),
    .q     (pins_s)
  );
  assign {dis_live_s, chg_live_s, rail_ok_s, rail_low_s,
          hard_off_n_s, sda_s, scl_s} = pins_s;

  // Start and stop are seen on the oversampled pins, since the bus clock
  // does not toggle across them.
  assign bus_start = scl_s & sda_prev & ~sda_s;
  assign bus_stop  = scl_s & ~sda_prev & sda_s;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_prev <= 1'b1;
    end else begin
      sda_prev <= sda_s;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_frame <= 1'b0;
    end else if (bus_start) begin
      in_frame <= 1'b1;
    end else if (bus_stop) begin
      in_frame <= 1'b0;
    end
  end

  // Holds the link logic cleared while idle and from each start until the
  // bus clock first goes low, so every address phase begins fresh.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_clear <= 1'b1;
    end else if (bus_start || !in_frame) begin
      frame_clear <= 1'b1;
    end else if (!scl_s) begin
      frame_clear <= 1'b0;
    end
  end

  assign link_clear = reset | frame_clear | por_oe;
  assign link_hard  = reset | por_oe;

  rst_timer #(.DELAY(POR_DELAY_CYCLES)) u_por_timer (
    .clk   (clk_sys),
    .reset (reset),
    .hold  (~hard_off_n_s | rail_low_s),
    .arm   (rail_ok_s),
    .done  (por_done)
  );

  assign next_por_active = ~por_done;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      por_oe <= 1'b1;
    end else begin
      por_oe <= next_por_active;
    end
  end

  sync2 #(.WIDTH(2)) u_evt_sync (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({ara_toggle, cfg_toggle}),
    .q     (evt_s)
  );
  assign {ara_s, cfg_s} = evt_s;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_prev <= 1'b0;
      ara_prev <= 1'b0;
    end else begin
      cfg_prev <= cfg_s;
      ara_prev <= ara_s;
    end
  end

  // The toggle handshake guarantees cfg_hold is stable when sampled here.
  assign cfg_strobe = cfg_s ^ cfg_prev;
  assign ara_strobe = ara_s ^ ara_prev;
  assign interrupt_clear_bit     = cfg_strobe & cfg_hold[`CFG_INT_CLEAR];
  assign soft_off   = config_word[`CFG_SOFT_OFF];
  assign run        = ~por_oe & ~soft_off;

  // Only the reset path clears the config, so leaving soft-off keeps it.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_word <= `CFG_RESET;
    end else if (por_oe) begin
      config_word <= `CFG_RESET;
    end else if (cfg_strobe) begin
      config_word <= cfg_hold & `CFG_STORE_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      counter_clear    <= 1'b0;
      functions_enable <= 1'b0;
    end else begin
      counter_clear    <= ~por_oe & cfg_strobe &
                          cfg_hold[`CFG_COUNTER_CLEAR];
      functions_enable <= run;
    end
  end

  assign sticky_set = {discharge_overcurrent_event,
                       charge_overcurrent_event, compare_interrupt};

  // A new event beats a simultaneous clear write.
  for (genvar i = 0; i < 3; i++) begin : g_sticky
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        sticky[i] <= 1'b0;
      end else if (!run) begin
        sticky[i] <= 1'b0;
      end else if (sticky_set[i]) begin
        sticky[i] <= 1'b1;
      end else if (interrupt_clear_bit) begin
        sticky[i] <= 1'b0;
      end
    end
  end
  assign {discharge_overcurrent_flag, charge_overcurrent_flag,
          compare_event_flag} = sticky;

  always_comb begin
    next_charging = charging_direction_flag;
    if (charge_detect) begin
      next_charging = 1'b1;
    end else if (discharge_detect) begin
      next_charging = 1'b0;
    end
  end
  assign dir_change = run & (next_charging != charging_direction_flag);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      charging_direction_flag <= 1'b0;
    end else if (por_oe) begin
      charging_direction_flag <= 1'b0;
    end else if (run) begin
      charging_direction_flag <= next_charging;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      direction_flip_flag <= 1'b0;
    end else if (!run) begin
      direction_flip_flag <= 1'b0;
    end else if (dir_change) begin
      direction_flip_flag <= 1'b1;
    end else if (interrupt_clear_bit) begin
      direction_flip_flag <= 1'b0;
    end
  end

  assign alert_raise = run & ((|sticky_set) |
                       (dir_change & config_word[`CFG_DIR_INT_EN]));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alert_oe <= 1'b0;
    end else if (!run) begin
      alert_oe <= 1'b0;
    end else if (alert_raise) begin
      alert_oe <= 1'b1;
    end else if (interrupt_clear_bit || ara_strobe) begin
      alert_oe <= 1'b0;
    end
  end

  // Returns one where the gate line must be pulled low.
  function automatic logic gate_pull(input logic hi, input logic lo,
                                     input logic flag, input logic live);
    logic pull;
    pull = 1'b0;
    case ({hi, lo})
      2'b00:   pull = ~flag;
      2'b01:   pull = 1'b1;
      2'b10:   pull = 1'b0;
      default: pull = ~live;
    endcase
    return pull;
  endfunction : gate_pull

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      charge_gate_drive_oe    <= 1'b0;
      discharge_gate_drive_oe <= 1'b0;
    end else begin
      charge_gate_drive_oe    <= ~next_por_active & gate_pull(
        config_word[`CFG_CHARGE_HIGH], config_word[`CFG_CHARGE_LOW],
        charge_overcurrent_flag, chg_live_s);
      discharge_gate_drive_oe <= ~next_por_active & gate_pull(
        config_word[`CFG_DISCHARGE_HIGH], config_word[`CFG_DISCHARGE_LOW],
        discharge_overcurrent_flag, dis_live_s);
    end
  end

  always_comb begin
    status_now                     = `STATUS_ONES;
    status_now[`ST_DISCHARGE_OC]   = discharge_overcurrent_flag;
    status_now[`ST_CHARGE_OC]      = charge_overcurrent_flag;
    status_now[`ST_COMPARE]        = compare_event_flag;
    status_now[`ST_COUNTER_SELECT] = config_word[`CFG_COUNTER_SELECT];
    status_now[`ST_SOFT_OFF]       = soft_off;
    status_now[`ST_CHARGING]       = charging_direction_flag;
    status_now[`ST_DIR_FLIP]       = direction_flip_flag;
  end

  // The link reads a snapshot frozen for the whole frame, so a byte never
  // mixes bits from two moments.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      device_status_word <= `STATUS_ONES;
      status_snap        <= `STATUS_ONES;
      alert_snap         <= 1'b0;
    end else begin
      device_status_word <= status_now;
      if (!in_frame) begin
        status_snap <= status_now;
        alert_snap  <= alert_oe;
      end
    end
  end

  // Link side, clocked by the bus clock.
  logic [3:0]  bit_cnt;
  byte_t       shift_in;
  byte_t       byte_now;
  link_phase_t phase;
  logic        ack_req;
  logic        tx_second;
  logic        ara_mode;
  byte_t       tx_byte;
  byte_t       command;
  byte_t       data_lo;
  logic        first_ack;

  assign byte_now  = {shift_in[6:0], sda_in};
  assign first_ack = (bit_cnt == `BIT_ACK) && (phase == PH_READ) && !ack_req;

  always_ff @(posedge scl_clk or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt  <= 4'h0;
      shift_in <= 8'h00;
    end else begin
      bit_cnt  <= (bit_cnt == `BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
      shift_in <= byte_now;
    end
  end

  always_ff @(posedge scl_clk or posedge link_clear) begin
    if (link_clear) begin
      phase     <= PH_ADDR;
      ack_req   <= 1'b0;
      tx_byte   <= `IDLE_BYTE;
      tx_second <= 1'b0;
      ara_mode  <= 1'b0;
    end else if (bit_cnt == `BIT_LAST) begin
      ack_req <= 1'b0;
      case (phase)
        PH_ADDR: begin
          if (byte_now[7:1] == `DEV_ADDR) begin
            ack_req <= 1'b1;
            if (byte_now[0] == `RW_READ) begin
              phase    <= PH_READ;
              tx_byte  <= (command == `CMD_STATUS_READ) ?
                          status_snap[7:0] : `IDLE_BYTE;
              ara_mode <= 1'b0;
            end else begin
              phase <= PH_CMD;
            end
          end else if (byte_now[7:1] == `ARA_ADDR &&
                       byte_now[0] == `RW_READ && alert_snap) begin
            ack_req  <= 1'b1;
            phase    <= PH_READ;
            tx_byte  <= `ARA_REPLY;
            ara_mode <= 1'b1;
          end else begin
            phase <= PH_SKIP;
          end
        end
        PH_CMD: begin
          ack_req <= 1'b1;
          phase   <= PH_WLO;
        end
        PH_WLO: begin
          ack_req <= 1'b1;
          phase   <= PH_WHI;
        end
        PH_WHI: begin
          ack_req <= 1'b1;
          phase   <= PH_SKIP;
        end
        PH_READ: begin
          phase <= PH_READ;
        end
        default: begin
          phase <= PH_SKIP;
        end
      endcase
    end else if (first_ack) begin
      if (sda_in) begin
        phase <= PH_SKIP;
      end else begin
        tx_second <= 1'b1;
        tx_byte   <= (!ara_mode && !tx_second &&
                      command == `CMD_STATUS_READ) ?
                     status_snap[15:8] : `IDLE_BYTE;
      end
    end
  end

  // These survive start and stop; only the device reset clears them.
  always_ff @(posedge scl_clk or posedge link_hard) begin
    if (link_hard) begin
      command    <= `CMD_NONE;
      data_lo    <= 8'h00;
      cfg_hold   <= `CFG_RESET;
      cfg_toggle <= 1'b0;
      ara_toggle <= 1'b0;
    end else if (bit_cnt == `BIT_LAST) begin
      case (phase)
        PH_CMD: command <= byte_now;
        PH_WLO: data_lo <= byte_now;
        PH_WHI: begin
          if (command == `CMD_WRITE_CONFIG) begin
            cfg_hold   <= {byte_now, data_lo};
            cfg_toggle <= ~cfg_toggle;
          end
        end
        default: begin
        end
      endcase
    end else if (first_ack && ara_mode && !tx_second) begin
      ara_toggle <= ~ara_toggle;
    end
  end

  // The data line is driven only to acknowledge or to answer a read.
  always_ff @(negedge scl_clk or posedge link_clear) begin
    if (link_clear) begin
      sda_oe <= 1'b0;
    end else if (bit_cnt == `BIT_ACK) begin
      sda_oe <= ack_req;
    end else if (phase == PH_READ) begin
      sda_oe <= ~tx_byte[`BIT_TOP - bit_cnt[2:0]];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_HARD_OFF: assert property (!hard_off_n_s |-> ##[1:2] por_oe)
    else $error("hard-off did not assert reset output");
  AST_RAIL_LOW: assert property (rail_low_s |-> ##2 por_oe)
    else $error("low rail did not assert reset output");
  AST_RELEASE: assert property ($fell(por_oe) |-> $past(rail_ok_s, 2))
    else $error("reset released without rail above threshold");
  AST_GATES_HIZ: assert property (por_oe |->
    !charge_gate_drive_oe && !discharge_gate_drive_oe)
    else $error("gate drive active during reset timeout");
  AST_SOFT_CLEAR: assert property (soft_off |=>
    !alert_oe && !direction_flip_flag && sticky == 3'h0)
    else $error("flags or alert survive soft shutdown");
  AST_OD_SET: assert property (discharge_overcurrent_event && run |=>
    discharge_overcurrent_flag)
    else $error("discharge overcurrent not latched");
  AST_INTERRUPT_CLEAR_BIT: assert property (interrupt_clear_bit && run && !compare_interrupt |=>
    !compare_event_flag)
    else $error("clear write left compare flag set");
  AST_MIRROR: assert property (cfg_strobe && !por_oe |=> ##1
    device_status_word[`ST_COUNTER_SELECT] ==
    $past(cfg_hold[`CFG_COUNTER_SELECT], 2))
    else $error("counter select not mirrored");
  AST_SOFT_IND: assert property ($rose(soft_off) |=>
    device_status_word[`ST_SOFT_OFF] && !functions_enable)
    else $error("soft shutdown not indicated");
  AST_DIR_FLIP: assert property (dir_change |=> direction_flip_flag)
    else $error("direction change not latched");
  AST_ARA_DROP: assert property (ara_strobe && !alert_raise |=>
    !alert_oe)
    else $error("alert held after alert response");
  AST_ONES: assert property (!in_frame |=>
    (status_snap & `STATUS_ONES) == `STATUS_ONES)
    else $error("fixed status bits not one");

  COV_SOFT_ENTRY: cover property ($rose(soft_off));
  COV_ARA: cover property (ara_strobe);
  COV_POR_RELEASE: cover property ($fell(por_oe));
  COV_OVERCURRENT: cover property ($rose(discharge_overcurrent_flag));

endmodule : gauge_status_shutdown_smbus

`default_nettype wire

// [gauge_params.svh]
`ifndef GAUGE_PARAMS_SVH
`define GAUGE_PARAMS_SVH

// Timing.
`define CLK_SYS_MHZ        100
`define POR_DELAY_US       25000
`define POR_DELAY_CYCLES   (`POR_DELAY_US * `CLK_SYS_MHZ)

// Two-wire bus addresses, replies and command codes.
`define DEV_ADDR           7'h47
`define ARA_ADDR           7'h0c
`define ARA_REPLY          8'h8f
`define IDLE_BYTE          8'hff
`define RW_READ            1'h1
`define CMD_NONE           8'hff
`define CMD_WRITE_CONFIG   8'h04
`define CMD_STATUS_READ    8'h02
`define BIT_LAST           4'h7
`define BIT_ACK            4'h8
`define BIT_TOP            3'h7

// Configuration word.
`define CFG_RESET          16'h0000
`define CFG_STORE_MASK     16'hfe7f
`define CFG_CHARGE_LOW     0
`define CFG_CHARGE_HIGH    1
`define CFG_DISCHARGE_LOW  2
`define CFG_DISCHARGE_HIGH 3
`define CFG_COUNTER_SELECT 6
`define CFG_INT_CLEAR      7
`define CFG_COUNTER_CLEAR  8
`define CFG_SOFT_OFF       9
`define CFG_DIR_INT_EN     10

// Status word.
`define STATUS_ONES        16'hff01
`define ST_DISCHARGE_OC    7
`define ST_CHARGE_OC       6
`define ST_COMPARE         5
`define ST_COUNTER_SELECT  4
`define ST_SOFT_OFF        3
`define ST_CHARGING        2
`define ST_DIR_FLIP        1

`endif

// [gauge_pkg.sv]
`default_nettype none

package gauge_pkg;

  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [2:0] {
    PH_ADDR,
    PH_CMD,
    PH_WLO,
    PH_WHI,
    PH_READ,
    PH_SKIP
  } link_phase_t;

endpackage : gauge_pkg

`default_nettype wire

// [sync2.sv]
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sync2

`default_nettype wire

// [rst_timer.sv]
`default_nettype none

module rst_timer #(
  parameter int DELAY = 1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic hold,
  input  wire logic arm,
  output logic      done
);

  localparam int CW = $clog2(DELAY + 1);

  logic [CW-1:0] count;

  // Release comes only after DELAY armed cycles without a hold.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      done  <= 1'b0;
    end else if (hold) begin
      count <= '0;
      done  <= 1'b0;
    end else if (arm && !done) begin
      if (count == CW'(DELAY - 1)) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : rst_timer

`default_nettype wire

// [smbus_host_model.sv]
`default_nettype none
`include "gauge_params.svh"

module smbus_host_model import gauge_pkg::*; (
  // Bus pins
  output var logic scl_clk,
  output logic     sda_in,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_drv = 1'b1;
  // The data line has a pull-up, so a released line reads high.
  assign sda_in = sda_drv & ~sda_oe;
  initial scl_clk = 1'b1;

  task automatic clk_bit(input logic b, output logic r);
    sda_drv = b;
    #20 scl_clk = 1'b1;
    #20 r = sda_in;
    #20 scl_clk = 1'b0;
    #20;
  endtask : clk_bit

  task automatic start;
    sda_drv = 1'b1;
    #20 scl_clk = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl_clk = 1'b0;
    #60;
  endtask : start

  task automatic stop;
    sda_drv = 1'b0;
    #20 scl_clk = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask : stop

  task automatic send(input byte_t d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : send

  task automatic recv(input logic last, output byte_t d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask : recv

  task automatic write_cfg(input word_t w, output logic ok);
    logic a0, a1, a2, a3;
    start();
    send({`DEV_ADDR, 1'b0}, a0);
    send(`CMD_WRITE_CONFIG, a1);
    send(w[7:0], a2);
    send(w[15:8], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : write_cfg

  task automatic read_word(input byte_t cmd, output word_t w);
    logic a;
    start();
    send({`DEV_ADDR, 1'b0}, a);
    send(cmd, a);
    start();
    send({`DEV_ADDR, 1'b1}, a);
    recv(1'b0, w[7:0]);
    recv(1'b1, w[15:8]);
    stop();
  endtask : read_word

  task automatic recv_byte(input byte_t addr, output logic ack,
                           output byte_t d);
    d = 8'hff;
    start();
    send(addr, ack);
    if (ack) recv(1'b1, d);
    stop();
  endtask : recv_byte
endmodule : smbus_host_model

`default_nettype wire

// [gauge_status_shutdown_smbus_tb.sv]
`default_nettype none
`include "gauge_params.svh"

module gauge_status_shutdown_smbus_tb import gauge_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR_CYC = 20;
  logic  clk_sys = 1'b0, reset = 1'b1, hard_off_n = 1'b1, rail_low = 1'b0;
  logic  ev_dis = 1'b0, ev_ch = 1'b0, ev_cmp = 1'b0;
  logic  det_ch = 1'b0, det_dis = 1'b0, rail_ok = 1'b1;
  logic  scl_clk, sda_in, sda_oe, alert_oe, por_oe, cg_oe, dg_oe, fn_en;
  logic  ack, ok;
  byte_t b;
  word_t w, cfg, st;
  int    error_cnt, checks;

  always #5 clk_sys = ~clk_sys;

  gauge_status_shutdown_smbus #(.POR_DELAY_CYCLES(POR_CYC))
  gauge_status_shutdown_smbus_inst (
    .clk_sys(clk_sys), .reset(reset), .scl_clk(scl_clk),
    .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
    .alert_out(), .alert_oe(alert_oe),
    .hard_off_n(hard_off_n), .rail_below_low_threshold(rail_low),
    .rail_above_release_threshold(rail_ok), .por_out(), .por_oe(por_oe),
    .charge_overcurrent_live(1'b0), .discharge_overcurrent_live(1'b0),
    .charge_gate_drive_out(), .charge_gate_drive_oe(cg_oe),
    .discharge_gate_drive_out(), .discharge_gate_drive_oe(dg_oe),
    .discharge_overcurrent_event(ev_dis), .charge_overcurrent_event(ev_ch),
    .compare_interrupt(ev_cmp), .charge_detect(det_ch),
    .discharge_detect(det_dis), .config_word(cfg), .counter_clear(),
    .functions_enable(fn_en), .device_status_word(st));

  smbus_host_model smbus_host_model_inst (
    .scl_clk(scl_clk), .sda_in(sda_in), .sda_oe(sda_oe));

  // Wide enough for the joined flag and status compares below.
  task automatic check(input string what, input logic [35:0] seen,
                       input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_por;
    int n;
    n = 0;
    while (por_oe === 1'b1 && n < 100) begin
      check("gates", {cg_oe, dg_oe}, 0);
      tick(1);
      n++;
    end
    check("por delay", word_t'(n >= POR_CYC && n <= POR_CYC + 8), 1);
    if (n >= 100) stop_test();
  endtask : wait_por

  task automatic write(input word_t v);
    smbus_host_model_inst.write_cfg(v, ok);
    check("ack", ok, 1);
    tick(10);
  endtask : write

  task automatic t_por;
    check("por", por_oe, 1);
    check("status", st, 16'hff01);
    wait_por();
    $display("power-on test done");
  endtask : t_por

  task automatic t_events;
    ev_dis = 1'b1;
    tick(1);
    ev_dis = 1'b0;
    ev_ch = 1'b1;
    tick(1);
    ev_ch = 1'b0;
    ev_cmp = 1'b1;
    det_ch = 1'b1;
    tick(1);
    ev_cmp = 1'b0;
    det_ch = 1'b0;
    tick(2);
    check("flags", st & 16'hfffd, 16'hffe5);
    check("alert", alert_oe, 1);
    det_dis = 1'b1;
    tick(1);
    det_dis = 1'b0;
    tick(2);
    check("flip", st, 16'hffe3);
    write(16'h0080);
    check("cleared", st, 16'hff01);
    check("alert off", alert_oe, 0);
    $display("event test done");
  endtask : t_events

  task automatic t_read;
    write(16'h0040);
    check("config", cfg, 16'h0040);
    smbus_host_model_inst.read_word(`CMD_STATUS_READ, w);
    check("read word", w, 16'hff11);
    ev_dis = 1'b1;
    tick(1);
    ev_dis = 1'b0;
    tick(2);
    smbus_host_model_inst.recv_byte({`DEV_ADDR, 1'b1}, ack, b);
    check("poll", {ack, b}, 9'h191);
    smbus_host_model_inst.recv_byte({7'h46, 1'b1}, ack, b);
    check("other addr", ack, 0);
    $display("read test done");
  endtask : t_read

  task automatic t_soft;
    write(16'h020a);
    check("soft st", st, 16'hff09);
    check("soft alert", alert_oe, 0);
    check("soft fn", {fn_en, cg_oe, dg_oe}, 0);
    ev_ch = 1'b1;
    tick(1);
    ev_ch = 1'b0;
    tick(2);
    check("soft hold", st, 16'hff09);
    write(16'h0040);
    check("resume", {por_oe, fn_en, st}, {2'b01, 16'hff11});
    $display("soft-off test done");
  endtask : t_soft

  task automatic t_ara;
    ev_cmp = 1'b1;
    tick(1);
    ev_cmp = 1'b0;
    tick(2);
    smbus_host_model_inst.recv_byte({`ARA_ADDR, 1'b1}, ack, b);
    check("ara", {ack, b}, 9'h18f);
    tick(8);
    check("ara alert", {alert_oe, st}, {1'b0, 16'hff31});
    $display("alert test done");
  endtask : t_ara

  task automatic t_hard;
    hard_off_n = 1'b0;
    tick(6);
    check("hard", {por_oe, cfg, st}, {1'b1, 16'h0, 16'hff01});
    hard_off_n = 1'b1;
    wait_por();
    rail_low = 1'b1;
    rail_ok = 1'b0;
    tick(4);
    check("low rail", por_oe, 1);
    rail_low = 1'b0;
    tick(30);
    check("rail wait", por_oe, 1);
    rail_ok = 1'b1;
    wait_por();
    $display("hard-off test done");
  endtask : t_hard

  initial begin
    tick(10);
    reset = 1'b0;
    t_por();
    t_events();
    t_read();
    t_soft();
    t_ara();
    t_hard();
    stop_test();
  end
endmodule : gauge_status_shutdown_smbus_tb

`default_nettype wire
